// >>> pkg/apm_pkg.sv
// Constants, carrier types and index tables of the alternate pin multiplexer; the routing lookup is in apm_mux.
// Contract
// - Seven option bits (all but bit 4) relocate alternate functions.
// - Remapped function leaves its default pin.
// - Remap never changes general-purpose pin capability.
// - Reset gives port function; enable selects alternate.
// - Bit 3 break input, bit 2 clock out.
// - Bit 1 puts timer A ch3 on D2.
// - Bit 0 puts converter trigger on D3.
// - Bit 7 puts tone output on D4.
// - Halt disables oscillator pin input and output.
// - Halt pull-up: off if oscillator wakes, else configured.
// - Debug pin is pulled-up input during/after reset.
// - I2C default pins are true open drain.
// - Interrupt pin events reach top-level interrupt line.
// - Bit 6 moves I2C to B5 and B4.
// - Bit 5 moves complementary outputs, trigger to B0-B3.
// - Bit 1 puts timer B ch1 on A3.
package apm_pkg;

   // Sizes of the pin and function tables.
   localparam int NUM_PINS = 23;
   localparam int NUM_FUNCS = 15;
   localparam int NUM_REMAP = 8;
   localparam logic [7:0] REMAP_RESET = 8'h00;

   // Positions of the remap option bits.
   localparam int RB_CONV_TRIG = 0;
   localparam int RB_TIMER_SWAP = 1;
   localparam int RB_CLK_OUT = 2;
   localparam int RB_BREAK = 3;
   localparam int RB_ADV_COMP = 5;
   localparam int RB_I2C = 6;
   localparam int RB_TONE = 7;

   // Pin indices within the pad vectors.
   localparam logic [4:0] PIN_PA1 = 5'h00;
   localparam logic [4:0] PIN_PA3 = 5'h01;
   localparam logic [4:0] PIN_PB0 = 5'h02;
   localparam logic [4:0] PIN_PB1 = 5'h03;
   localparam logic [4:0] PIN_PB2 = 5'h04;
   localparam logic [4:0] PIN_PB3 = 5'h05;
   localparam logic [4:0] PIN_PB4 = 5'h06;
   localparam logic [4:0] PIN_PB5 = 5'h07;
   localparam logic [4:0] PIN_PC0 = 5'h08;
   localparam logic [4:0] PIN_PD0 = 5'h09;
   localparam logic [4:0] PIN_PD1 = 5'h0A;
   localparam logic [4:0] PIN_PD2 = 5'h0B;
   localparam logic [4:0] PIN_PD3 = 5'h0C;
   localparam logic [4:0] PIN_PD4 = 5'h0D;
   localparam logic [4:0] PIN_PE0 = 5'h0E;
   localparam logic [4:0] PIN_PE1 = 5'h0F;
   localparam logic [4:0] PIN_PE2 = 5'h10;
   localparam logic [4:0] PIN_PE3 = 5'h11;
   localparam logic [4:0] PIN_PH4 = 5'h12;
   localparam logic [4:0] PIN_PH5 = 5'h13;
   localparam logic [4:0] PIN_PH6 = 5'h14;
   localparam logic [4:0] PIN_PH7 = 5'h15;
   localparam logic [4:0] PIN_IRQ = 5'h16;

   // Alternate function indices within the peripheral vectors.
   localparam logic [3:0] F_TMB_CH1 = 4'h0;
   localparam logic [3:0] F_TMB_CH2 = 4'h1;
   localparam logic [3:0] F_TMA_CH1 = 4'h2;
   localparam logic [3:0] F_TMA_CH2 = 4'h3;
   localparam logic [3:0] F_TMA_CH3 = 4'h4;
   localparam logic [3:0] F_BREAK_IN = 4'h5;
   localparam logic [3:0] F_CLK_OUT = 4'h6;
   localparam logic [3:0] F_CONV_TRIG = 4'h7;
   localparam logic [3:0] F_TONE = 4'h8;
   localparam logic [3:0] F_I2C_SDA = 4'h9;
   localparam logic [3:0] F_I2C_SCL = 4'hA;
   localparam logic [3:0] F_ADV_ETR = 4'hB;
   localparam logic [3:0] F_ADV_CH1N = 4'hC;
   localparam logic [3:0] F_ADV_CH2N = 4'hD;
   localparam logic [3:0] F_ADV_CH3N = 4'hE;

   // Port-side request for one pin: output level, drive enable, pull-up.
   typedef struct packed {
      logic out;
      logic oe;
      logic pu;
   } apm_gpio_s;

   // Peripheral-side request for one function: enable, output level, drive enable.
   typedef struct packed {
      logic en;
      logic out;
      logic oe;
   } apm_func_s;

   // Result of the routing lookup for one pin.
   typedef struct packed {
      logic hit;
      logic [3:0] fid;
   } apm_route_s;

   // Option loader states.
   typedef enum logic [0:0] {
      LD_WAIT = 1'b0,
      LD_HELD = 1'b1
   } apm_load_e;

endpackage : apm_pkg

// >>> verilog/apm_pin_cell.sv
// One pad cell: output select, pull-up control, input synchroniser.
`timescale 1ns/1ps
module apm_pin_cell #(
   parameter bit TRUE_OD = 1'b0,
   parameter bit PU_IN_RESET = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire apm_pkg::apm_gpio_s gpio_i,
   input wire logic alt_act_i,
   input wire logic alt_out_i,
   input wire logic alt_oe_i,
   input wire logic gate_i,
   input wire logic pu_on_i,
   input wire logic pu_off_i,
   input wire logic pad_in_i,
   output logic pad_o,
   output logic pad_oe_o,
   output logic pad_pu_o,
   output logic pin_in_o
);

   logic sync_ff1; // First synchroniser stage, read only by the second.
   logic sync_ff2; // Second synchroniser stage.
   logic next_drv;
   logic next_oe;
   logic next_pu;

   // Output selection; the port path passes when no alternate is active, except where open-drain, pull-up or gating overrides apply.
   always_comb begin
      next_drv = alt_act_i ? alt_out_i : gpio_i.out;
      next_oe = alt_act_i ? alt_oe_i : gpio_i.oe;
      next_pu = gpio_i.pu;
      if (TRUE_OD) begin
         // No high-side driver: a high level only releases the pad.
         next_oe = next_oe & ~next_drv;
         next_drv = 1'b0;
         next_pu = 1'b0;
      end
      if (pu_on_i) begin
         next_pu = 1'b1;
      end
      if (gate_i) begin
         next_oe = 1'b0;
         next_pu = pu_off_i ? 1'b0 : gpio_i.pu;
      end
   end

   // Pad drive registers; the pull-up reset value is a per-pin constant.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pad_o <= 1'b0;
         pad_oe_o <= 1'b0;
         pad_pu_o <= PU_IN_RESET;
      end else begin
         pad_o <= next_drv;
         pad_oe_o <= next_oe;
         pad_pu_o <= next_pu;
      end
   end

   // Two-stage synchroniser, then the gated input register.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_ff1 <= 1'b0;
         sync_ff2 <= 1'b0;
         pin_in_o <= 1'b0;
      end else begin
         sync_ff1 <= pad_in_i;
         sync_ff2 <= sync_ff1;
         pin_in_o <= gate_i ? 1'b0 : sync_ff2;
      end
   end

endmodule : apm_pin_cell

// >>> verilog/apm_mux.sv
// Top of the alternate pin multiplexer: remap latch, routing, function inputs, interrupt pin.
`timescale 1ns/1ps
module apm_mux #(
   parameter int NUM_PINS = apm_pkg::NUM_PINS,
   parameter int NUM_FUNCS = apm_pkg::NUM_FUNCS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] opt_remap_i,
   input wire logic halt_i,
   input wire logic external_fast_osc_wakeup_i,
   input wire logic irq_cfg_i,
   input wire apm_pkg::apm_gpio_s [NUM_PINS-1:0] gpio_i,
   input wire apm_pkg::apm_func_s [NUM_FUNCS-1:0] func_i,
   input wire logic [NUM_PINS-1:0] pad_in_i,
   output logic [NUM_PINS-1:0] pad_o,
   output logic [NUM_PINS-1:0] pad_oe_o,
   output logic [NUM_PINS-1:0] pad_pu_o,
   output logic [NUM_PINS-1:0] pin_in_o,
   output logic [NUM_FUNCS-1:0] func_in_o,
   output logic [7:0] remap_o,
   output logic top_level_irq_o
);

   // The routing table is fixed; other sizes cannot be served.
   if (NUM_PINS != apm_pkg::NUM_PINS || NUM_FUNCS != apm_pkg::NUM_FUNCS) begin : g_size_check
      $error("apm_mux: pin or function count does not match the routing table.");
   end

   // Routing lookup: which function, if any, a pin carries under the given option bits.
   function automatic apm_pkg::apm_route_s route(input logic [4:0] pin, input logic [7:0] rm);
      apm_pkg::apm_route_s r;
      r.hit = 1'b1;
      r.fid = apm_pkg::F_TMB_CH1;
      case (pin)
         apm_pkg::PIN_PA3: begin
            r.fid = rm[apm_pkg::RB_TIMER_SWAP] ? apm_pkg::F_TMB_CH1 : apm_pkg::F_TMA_CH3;
         end
         apm_pkg::PIN_PD2: begin
            r.fid = rm[apm_pkg::RB_TIMER_SWAP] ? apm_pkg::F_TMA_CH3 : apm_pkg::F_TMB_CH1;
         end
         apm_pkg::PIN_PD0: begin
            // Break input wins when both bits are set.
            if (rm[apm_pkg::RB_BREAK]) begin
               r.fid = apm_pkg::F_BREAK_IN;
            end else if (rm[apm_pkg::RB_CLK_OUT]) begin
               r.fid = apm_pkg::F_CLK_OUT;
            end else begin
               r.fid = apm_pkg::F_TMB_CH2;
            end
         end
         apm_pkg::PIN_PD3: begin
            r.fid = rm[apm_pkg::RB_CONV_TRIG] ? apm_pkg::F_CONV_TRIG : apm_pkg::F_TMA_CH2;
         end
         apm_pkg::PIN_PD4: begin
            r.fid = rm[apm_pkg::RB_TONE] ? apm_pkg::F_TONE : apm_pkg::F_TMA_CH1;
         end
         apm_pkg::PIN_PB5: begin
            r.hit = rm[apm_pkg::RB_I2C];
            r.fid = apm_pkg::F_I2C_SDA;
         end
         apm_pkg::PIN_PB4: begin
            r.hit = rm[apm_pkg::RB_I2C];
            r.fid = apm_pkg::F_I2C_SCL;
         end
         apm_pkg::PIN_PB0: begin
            r.hit = rm[apm_pkg::RB_ADV_COMP];
            r.fid = apm_pkg::F_ADV_CH1N;
         end
         apm_pkg::PIN_PB1: begin
            r.hit = rm[apm_pkg::RB_ADV_COMP];
            r.fid = apm_pkg::F_ADV_CH2N;
         end
         apm_pkg::PIN_PB2: begin
            r.hit = rm[apm_pkg::RB_ADV_COMP];
            r.fid = apm_pkg::F_ADV_CH3N;
         end
         apm_pkg::PIN_PB3: begin
            r.hit = rm[apm_pkg::RB_ADV_COMP];
            r.fid = apm_pkg::F_ADV_ETR;
         end
         // Default homes, vacated when their function moves away.
         apm_pkg::PIN_PH4: begin
            r.hit = ~rm[apm_pkg::RB_ADV_COMP];
            r.fid = apm_pkg::F_ADV_ETR;
         end
         apm_pkg::PIN_PH5: begin
            r.hit = ~rm[apm_pkg::RB_ADV_COMP];
            r.fid = apm_pkg::F_ADV_CH3N;
         end
         apm_pkg::PIN_PH6: begin
            r.hit = ~rm[apm_pkg::RB_ADV_COMP];
            r.fid = apm_pkg::F_ADV_CH2N;
         end
         apm_pkg::PIN_PH7: begin
            r.hit = ~rm[apm_pkg::RB_ADV_COMP];
            r.fid = apm_pkg::F_ADV_CH1N;
         end
         apm_pkg::PIN_PE1: begin
            r.hit = ~rm[apm_pkg::RB_I2C];
            r.fid = apm_pkg::F_I2C_SCL;
         end
         apm_pkg::PIN_PE2: begin
            r.hit = ~rm[apm_pkg::RB_I2C];
            r.fid = apm_pkg::F_I2C_SDA;
         end
         apm_pkg::PIN_PE3: begin
            r.hit = ~rm[apm_pkg::RB_BREAK];
            r.fid = apm_pkg::F_BREAK_IN;
         end
         apm_pkg::PIN_PE0: begin
            r.hit = ~rm[apm_pkg::RB_CLK_OUT];
            r.fid = apm_pkg::F_CLK_OUT;
         end
         apm_pkg::PIN_PC0: begin
            r.hit = ~rm[apm_pkg::RB_CONV_TRIG];
            r.fid = apm_pkg::F_CONV_TRIG;
         end
         default: begin
            // Oscillator, debug and interrupt pins carry no routed function.
            r.hit = 1'b0;
         end
      endcase
      return r;
   endfunction : route

   // Open-drain functions only ever pull low.
   function automatic logic is_i2c(input logic [3:0] fid);
      return (fid == apm_pkg::F_I2C_SDA) || (fid == apm_pkg::F_I2C_SCL);
   endfunction : is_i2c

   apm_pkg::apm_load_e load_state; // Option loader state.
   logic [7:0] remap; // Held option bits steering all routing.
   logic [NUM_PINS-1:0] alt_act; // Pin is handed to its alternate function.
   logic [NUM_PINS-1:0] alt_out; // Alternate output level per pin.
   logic [NUM_PINS-1:0] alt_oe; // Alternate drive enable per pin.
   logic [NUM_PINS-1:0] gate; // Low-power gating per pin.
   logic [NUM_PINS-1:0] pu_on; // Forced pull-up per pin.
   logic [NUM_PINS-1:0] pu_off; // Forced pull-up release per pin.
   logic [NUM_FUNCS-1:0] next_func_in; // Pin level seen by each function.
   logic irq_prev; // Previous interrupt pin level for edge detection.

   // Option loader: the bits are sampled once at the first edge after reset.
   // Sampling after release keeps the asynchronous reset to constants only.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         load_state <= apm_pkg::LD_WAIT;
         remap <= apm_pkg::REMAP_RESET;
      end else begin
         case (load_state)
            apm_pkg::LD_WAIT: begin
               remap <= opt_remap_i;
               load_state <= apm_pkg::LD_HELD;
            end
            apm_pkg::LD_HELD: begin
               remap <= remap;
            end
            default: begin
               load_state <= apm_pkg::LD_WAIT;
            end
         endcase
      end
   end

   // Per-pin selection; a routed function takes the pin only while its peripheral is on.
   always_comb begin
      apm_pkg::apm_route_s r;
      r = '0;
      alt_act = '0;
      alt_out = '0;
      alt_oe = '0;
      gate = '0;
      pu_on = '0;
      pu_off = '0;
      for (int p = 0; p < NUM_PINS; p++) begin
         r = route(5'(p), remap);
         alt_act[p] = r.hit & func_i[r.fid].en;
         alt_out[p] = func_i[r.fid].out;
         alt_oe[p] = func_i[r.fid].oe;
         if (is_i2c(r.fid)) begin
            alt_oe[p] = func_i[r.fid].oe & ~func_i[r.fid].out;
         end
      end
      gate[apm_pkg::PIN_PA1] = halt_i;
      pu_off[apm_pkg::PIN_PA1] = halt_i & external_fast_osc_wakeup_i;
      // The debug pin stays pulled up unless the port turns it into an output.
      pu_on[apm_pkg::PIN_PD1] = ~gpio_i[apm_pkg::PIN_PD1].oe;
   end

   // Pad cells; only the two default I2C pins lack a high-side driver.
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      apm_pin_cell #(
         .TRUE_OD(p == apm_pkg::PIN_PE1 || p == apm_pkg::PIN_PE2),
         .PU_IN_RESET(p == apm_pkg::PIN_PD1)
      ) u_cell (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .gpio_i(gpio_i[p]),
         .alt_act_i(alt_act[p]),
         .alt_out_i(alt_out[p]),
         .alt_oe_i(alt_oe[p]),
         .gate_i(gate[p]),
         .pu_on_i(pu_on[p]),
         .pu_off_i(pu_off[p]),
         .pad_in_i(pad_in_i[p]),
         .pad_o(pad_o[p]),
         .pad_oe_o(pad_oe_o[p]),
         .pad_pu_o(pad_pu_o[p]),
         .pin_in_o(pin_in_o[p])
      );
   end

   // Function inputs follow the pin currently routed to them; idle I2C lines read high.
   always_comb begin
      apm_pkg::apm_route_s r;
      r = '0;
      next_func_in = '0;
      next_func_in[apm_pkg::F_I2C_SDA] = 1'b1;
      next_func_in[apm_pkg::F_I2C_SCL] = 1'b1;
      for (int p = 0; p < NUM_PINS; p++) begin
         r = route(5'(p), remap);
         if (r.hit && func_i[r.fid].en) begin
            next_func_in[r.fid] = pin_in_o[p];
         end
      end
   end

   // Function input register.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         func_in_o <= '0;
      end else begin
         func_in_o <= next_func_in;
      end
   end

   // Status copy of the held option bits.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         remap_o <= apm_pkg::REMAP_RESET;
      end else begin
         remap_o <= remap;
      end
   end

   // Interrupt pin: a falling edge gives a one-cycle pulse while configured.
   // The synchronised level is used, so the pulse lags the pad by four edges.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_prev <= 1'b0;
         top_level_irq_o <= 1'b0;
      end else begin
         irq_prev <= pin_in_o[apm_pkg::PIN_IRQ];
         top_level_irq_o <= irq_cfg_i & irq_prev & ~pin_in_o[apm_pkg::PIN_IRQ];
      end
   end

endmodule : apm_mux

// >>> test/apm_mux_monitor.sv
// Assertion checker for the alternate pin multiplexer, bound to its top module.
`timescale 1ns/1ps
module apm_mux_monitor #(
   parameter int NUM_PINS = apm_pkg::NUM_PINS,
   parameter int NUM_FUNCS = apm_pkg::NUM_FUNCS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] opt_remap_i,
   input wire logic halt_i,
   input wire logic external_fast_osc_wakeup_i,
   input wire logic irq_cfg_i,
   input wire apm_pkg::apm_gpio_s [NUM_PINS-1:0] gpio_i,
   input wire apm_pkg::apm_func_s [NUM_FUNCS-1:0] func_i,
   input wire logic [NUM_PINS-1:0] pad_in_i,
   input wire logic [NUM_PINS-1:0] pad_o,
   input wire logic [NUM_PINS-1:0] pad_oe_o,
   input wire logic [NUM_PINS-1:0] pad_pu_o,
   input wire logic [NUM_PINS-1:0] pin_in_o,
   input wire logic [NUM_FUNCS-1:0] func_in_o,
   input wire logic [7:0] remap_o,
   input wire logic top_level_irq_o
);
   // Cycles since reset release, saturating, so the remap hold is judged only once loaded.
   logic [1:0] age;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         age <= 2'h0;
      end else if (age != 2'h3) begin
         age <= age + 2'h1;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // The reset check must stay live during reset, so it overrides the default disable.
   reset_pullup_a: assert property (disable iff (1'b0) rst_i |-> pad_pu_o[apm_pkg::PIN_PD1])
      else $error("debug pin pull-up off in reset");
   tone_route_a: assert property (remap_o[apm_pkg::RB_TONE] && func_i[apm_pkg::F_TONE].en |=>
      pad_o[apm_pkg::PIN_PD4] == $past(func_i[apm_pkg::F_TONE].out)) else $error("tone pin wrong");
   break_route_a: assert property (remap_o[apm_pkg::RB_BREAK] && func_i[apm_pkg::F_BREAK_IN].en |=>
      pad_oe_o[apm_pkg::PIN_PD0] == $past(func_i[apm_pkg::F_BREAK_IN].oe)) else $error("break pin wrong");
   default_gone_a: assert property (remap_o[apm_pkg::RB_BREAK] |=>
      pad_oe_o[apm_pkg::PIN_PE3] == $past(gpio_i[apm_pkg::PIN_PE3].oe)) else $error("old pin kept");
   halt_gate_a: assert property (halt_i |=> !pad_oe_o[apm_pkg::PIN_PA1])
      else $error("oscillator pin driven in halt");
   halt_pullup_a: assert property (halt_i |=> pad_pu_o[apm_pkg::PIN_PA1] ==
      (!$past(external_fast_osc_wakeup_i) && $past(gpio_i[apm_pkg::PIN_PA1].pu))) else $error("halt pull-up wrong");
   i2c_drain_a: assert property (!remap_o[apm_pkg::RB_I2C] && func_i[apm_pkg::F_I2C_SDA].en |=>
      pad_oe_o[apm_pkg::PIN_PE2] == ($past(func_i[apm_pkg::F_I2C_SDA].oe) && !$past(func_i[apm_pkg::F_I2C_SDA].out))
      && !pad_o[apm_pkg::PIN_PE2] && !pad_pu_o[apm_pkg::PIN_PE2]) else $error("data pin not open drain");
   trig_input_a: assert property (remap_o[apm_pkg::RB_CONV_TRIG] && func_i[apm_pkg::F_CONV_TRIG].en |=>
      func_in_o[apm_pkg::F_CONV_TRIG] == $past(pin_in_o[apm_pkg::PIN_PD3])) else $error("trigger input wrong");
   irq_pulse_a: assert property ($fell(pin_in_o[apm_pkg::PIN_IRQ]) && irq_cfg_i |=>
      top_level_irq_o ##1 !top_level_irq_o) else $error("interrupt pulse wrong");
   remap_held_a: assert property (age == 2'h3 |-> $stable(remap_o))
      else $error("remap bits changed");
   cover property (halt_i && external_fast_osc_wakeup_i);
   cover property (top_level_irq_o);
   cover property (remap_o[apm_pkg::RB_BREAK] && func_i[apm_pkg::F_BREAK_IN].en);
endmodule : apm_mux_monitor

bind apm_mux apm_mux_monitor #(.NUM_PINS(NUM_PINS), .NUM_FUNCS(NUM_FUNCS)) mon (
   .clk_i(clk_i), .rst_i(rst_i), .opt_remap_i(opt_remap_i), .halt_i(halt_i),
   .external_fast_osc_wakeup_i(external_fast_osc_wakeup_i),
   .irq_cfg_i(irq_cfg_i), .gpio_i(gpio_i), .func_i(func_i), .pad_in_i(pad_in_i), .pad_o(pad_o),
   .pad_oe_o(pad_oe_o), .pad_pu_o(pad_pu_o), .pin_in_o(pin_in_o), .func_in_o(func_in_o),
   .remap_o(remap_o), .top_level_irq_o(top_level_irq_o));

// >>> test/apm_board_model.sv
// Board and pad model: resolves every pad from device drive, pull-up and external drivers.
`timescale 1ns/1ps
module apm_board_model (
   input wire logic clk_i,
   input wire logic [apm_pkg::NUM_PINS-1:0] pad_i,
   input wire logic [apm_pkg::NUM_PINS-1:0] oe_i,
   input wire logic [apm_pkg::NUM_PINS-1:0] pu_i,
   input wire logic [apm_pkg::NUM_PINS-1:0] ext_en_i,
   input wire logic [apm_pkg::NUM_PINS-1:0] ext_val_i,
   output logic [apm_pkg::NUM_PINS-1:0] pad_in_o
);
   // Toggles every cycle so a floating pad never reads as a steady level.
   logic flip = 1'b0;
   always @(posedge clk_i) begin
      flip <= !flip;
   end
   // Device drive wins, then the board, then the weak pull-up; a bare pad floats.
   always_comb begin
      for (int i = 0; i < apm_pkg::NUM_PINS; i++) begin
         if (oe_i[i]) begin
            pad_in_o[i] = pad_i[i];
         end else if (ext_en_i[i]) begin
            pad_in_o[i] = ext_val_i[i];
         end else if (pu_i[i]) begin
            pad_in_o[i] = 1'b1;
         end else begin
            pad_in_o[i] = flip ^ i[0];
         end
      end
   end
endmodule : apm_board_model

// >>> test/alt_function_remap_mux_bench.sv
// Self-checking testbench for the alternate pin multiplexer.
`timescale 1ns/1ps
module alt_function_remap_mux_bench;
   localparam int NP = apm_pkg::NUM_PINS;
   localparam int NF = apm_pkg::NUM_FUNCS;
   // Stimulus, board drive and observed outputs.
   logic clk_i = 1'b0;
   logic rst_i = 1'b0; // Raised 1 ns in, so the asynchronous reset sees a real edge before the first clock.
   logic halt = 1'b0;
   logic osc_wake = 1'b0;
   logic irqc = 1'b0;
   logic [7:0] opt = 8'h00;
   apm_pkg::apm_gpio_s [NP-1:0] gpio = '0;
   apm_pkg::apm_func_s [NF-1:0] func = '0;
   logic [NP-1:0] ext_en = '0;
   logic [NP-1:0] ext_val = '0;
   logic [NP-1:0] pad_in, pad, oe, pu, pin_in;
   logic [NF-1:0] fin;
   logic [7:0] remap;
   logic irq;
   int miscompares = 0;
   int compares = 0;

   // Free-running 125 MHz clock.
   initial begin
      forever #4 clk_i = ~clk_i;
   end

   apm_mux dut (.clk_i(clk_i), .rst_i(rst_i), .opt_remap_i(opt), .halt_i(halt),
      .external_fast_osc_wakeup_i(osc_wake),
      .irq_cfg_i(irqc), .gpio_i(gpio), .func_i(func), .pad_in_i(pad_in), .pad_o(pad), .pad_oe_o(oe),
      .pad_pu_o(pu), .pin_in_o(pin_in), .func_in_o(fin), .remap_o(remap), .top_level_irq_o(irq));
   apm_board_model board (.clk_i(clk_i), .pad_i(pad), .oe_i(oe), .pu_i(pu), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .pad_in_o(pad_in));

   // Moves n edges on and lands 1 ns later, where inputs change and outputs are settled.
   task step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : step

   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask : chk

   task close_out;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   // Resets with the given option bits, then shows that later option changes are ignored.
   task do_reset(input logic [7:0] r);
      rst_i = 1'b1;
      opt = r;
      gpio = '0;
      func = '0;
      ext_en = '0;
      step(3);
      chk("reset pullup", 8'h01, pu[apm_pkg::PIN_PD1]);
      chk("reset drive", 8'h01, oe == '0);
      step(1);
      rst_i = 1'b0;
      step(3);
      chk("remap", r, remap);
      opt = ~r;
      step(2);
      chk("remap held", r, remap);
   endtask : do_reset

   // A disabled function leaves the pin to the port; enabling it takes over.
   task t_default;
      do_reset(8'h00);
      gpio[apm_pkg::PIN_PD0] = 3'b110;
      func[apm_pkg::F_TMB_CH2] = 3'b001;
      step(2);
      chk("pd0 port", 8'h01, pad[apm_pkg::PIN_PD0]);
      func[apm_pkg::F_TMB_CH2] = 3'b101;
      step(2);
      chk("pd0 func", 8'h00, pad[apm_pkg::PIN_PD0]);
   endtask : t_default

   // Halt gates the oscillator pin; its pull-up depends on the wakeup clock.
   task t_halt;
      gpio[apm_pkg::PIN_PA1] = 3'b111;
      ext_en[apm_pkg::PIN_PA1] = 1'b1;
      ext_val[apm_pkg::PIN_PA1] = 1'b1;
      halt = 1'b1;
      osc_wake = 1'b1;
      step(5);
      chk("pa1 oe", 8'h00, oe[apm_pkg::PIN_PA1]);
      chk("pa1 in", 8'h00, pin_in[apm_pkg::PIN_PA1]);
      chk("pa1 pu off", 8'h00, pu[apm_pkg::PIN_PA1]);
      osc_wake = 1'b0;
      step(2);
      chk("pa1 pu on", 8'h01, pu[apm_pkg::PIN_PA1]);
      halt = 1'b0;
      step(2);
      chk("pa1 run", 8'h01, oe[apm_pkg::PIN_PA1]);
   endtask : t_halt

   // The default data pin releases on a high level and never pulls up.
   task t_i2c;
      gpio[apm_pkg::PIN_PE2] = 3'b001;
      func[apm_pkg::F_I2C_SDA] = 3'b111;
      step(2);
      chk("pe2 high", 8'h00, {oe[apm_pkg::PIN_PE2], pu[apm_pkg::PIN_PE2]});
      func[apm_pkg::F_I2C_SDA] = 3'b101;
      step(2);
      chk("pe2 low", 8'h02, {oe[apm_pkg::PIN_PE2], pad[apm_pkg::PIN_PE2]});
   endtask : t_i2c

   // A falling interrupt pin pulses the line once; unconfigured it stays quiet.
   task t_irq;
      int k;
      irqc = 1'b1;
      ext_en[apm_pkg::PIN_IRQ] = 1'b1;
      ext_val[apm_pkg::PIN_IRQ] = 1'b1;
      step(6);
      ext_val[apm_pkg::PIN_IRQ] = 1'b0;
      k = 0;
      while (irq !== 1'b1 && k < 10) begin
         step(1);
         k++;
      end
      if (k == 10) begin
         $display("mismatch irq pulse expected 1 seen 0");
         miscompares++;
         close_out();
      end
      step(1);
      chk("irq one cycle", 8'h00, irq);
      irqc = 1'b0;
      ext_val[apm_pkg::PIN_IRQ] = 1'b1;
      step(6);
      ext_val[apm_pkg::PIN_IRQ] = 1'b0;
      k = 0;
      repeat (8) begin
         step(1);
         if (irq === 1'b1) k++;
      end
      chk("irq masked", 8'h00, k[7:0]);
   endtask : t_irq

   // Every remap bit set: relocated functions appear, defaults leave, port use survives.
   task t_remap_all;
      logic [4:0] pl [8];
      pl = '{apm_pkg::PIN_PD0, apm_pkg::PIN_PD2, apm_pkg::PIN_PA3, apm_pkg::PIN_PD4,
         apm_pkg::PIN_PB0, apm_pkg::PIN_PB1, apm_pkg::PIN_PB2, apm_pkg::PIN_PB3};
      do_reset(8'hFF);
      func = {NF{3'b111}};
      func[apm_pkg::F_CLK_OUT] = 3'b101;
      func[apm_pkg::F_I2C_SDA] = 3'b101;
      // The trigger is an input: the device must not drive the pad, so the level comes from the board.
      func[apm_pkg::F_CONV_TRIG] = 3'b100;
      ext_en[apm_pkg::PIN_PD3] = 1'b1;
      ext_val[apm_pkg::PIN_PD3] = 1'b1;
      step(6);
      for (int i = 0; i < 8; i++) begin
         chk("moved pin", 8'h03, {pad[pl[i]], oe[pl[i]]});
      end
      chk("pb5 data", 8'h01, oe[apm_pkg::PIN_PB5]);
      chk("pb4 clock", 8'h02, {pad[apm_pkg::PIN_PB4], oe[apm_pkg::PIN_PB4]});
      chk("old pins", 8'h00, {oe[apm_pkg::PIN_PE3], oe[apm_pkg::PIN_PH7]});
      chk("trigger in", 8'h01, fin[apm_pkg::F_CONV_TRIG]);
      chk("pd3 in", 8'h01, pin_in[apm_pkg::PIN_PD3]);
      func[apm_pkg::F_BREAK_IN] = 3'b000;
      gpio[apm_pkg::PIN_PD0] = 3'b010;
      step(2);
      chk("pd0 port", 8'h01, {pad[apm_pkg::PIN_PD0], oe[apm_pkg::PIN_PD0]});
   endtask : t_remap_all

   // Clock output alone moves to the timer pin and leaves its default pin.
   task t_clkout;
      do_reset(8'h04);
      func[apm_pkg::F_CLK_OUT] = 3'b111;
      step(2);
      chk("pd0 clock", 8'h03, {pad[apm_pkg::PIN_PD0], oe[apm_pkg::PIN_PD0]});
      chk("pe0 free", 8'h00, oe[apm_pkg::PIN_PE0]);
   endtask : t_clkout

   initial begin
      // Start off the time-zero instant so the reset edge cannot race the design's processes.
      #1;
      t_default();
      t_halt();
      t_i2c();
      t_irq();
      t_remap_all();
      t_clkout();
      close_out();
   end
endmodule : alt_function_remap_mux_bench
